// ===== hw/host_pio_ports_burst_buffer.sv
// Purpose: host programmed-I/O ports, port interrupt priority, status
//          indicators and ping-pong burst channel output buffer
// Assumes: all inputs synchronous to clk_i; host-side firmware reaches
//          the block over classic Wishbone
// Notes:   buffer data flows from firmware to host memory
// Contract
// RL1: four independent programmed_io ports, each with command and status.
// RL2: six shared command/status registers, busy/done logic, interrupts.
// RL3: fixed interrupt priority: port 0, port 1, port 2, maintenance_port.
// RL4: simultaneous requests present the higher-priority port first.
// RL5: higher-priority of disk or tape goes to port 0, the other port 1.
// RL6: port 2 serves auxiliary device; lowest port is the maintenance_port.
// RL7: tape uses host mask bit 10, disk uses host mask bit 7.
// RL8: busy set while a port runs a command, cleared when it can accept.
// RL9: busy reflects programmed_io commands only, not control_block work.
// RL10: each busy flag drives one dedicated indicator, four in all.
// RL11: burst_channel data staged through two 256-word buffers alternately.
// RL12: one buffer fills while the other empties.
// RL13: burst length selectable from 1 to 256 sixteen-bit words.
// RL14: break between bursts selectable from 1 to 256 sync periods.
// RL15: bus request raised on any one of 8 selectable request lines.
// RL16: data_channel interface unused; all block data on burst_channel.
// RL17: activity indicator lit while burst_channel transfers data.
// RL18: self-test indicator lit during self-test and debug mode.
// RL19: buffers swap only when filling one is done and other drained.
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ns
`include "host_port_consts.svh"
module host_pio_ports_burst_buffer
  import host_port_pkg::*;
#(
  parameter int BUF_WORDS = 256
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  // host programmed-I/O side
  input  wire logic        pio_we_i,
  input  wire logic [2:0]  pio_reg_i,
  input  wire logic [15:0] pio_wdata_i,
  input  wire logic        pio_start_i,
  output logic      [15:0] pio_rdata_o,
  output logic      [3:0]  pio_busy_o,
  output logic      [3:0]  pio_done_o,
  input  wire logic [15:0] host_mask_i,
  output logic             host_int_o,
  output logic      [1:0]  host_int_port_o,
  input  wire logic        host_int_ack_i,
  // burst channel
  output logic      [7:0]  chan_req_o,
  input  wire logic        chan_grant_i,
  input  wire logic        chan_sync_i,
  output logic      [15:0] chan_data_o,
  output logic             chan_valid_o,
  output logic             dch_req_o,
  // indicators
  output logic      [3:0]  led_busy_o,
  output logic             led_chan_active_o,
  output logic             led_selftest_o
);
  import host_port_pkg::*;

  localparam int PW = $clog2(BUF_WORDS + 1);
  // word index inside one buffer, sized for any depth, not just powers of 2
  localparam int AW = $clog2(BUF_WORDS);

  if (BUF_WORDS < 2 || BUF_WORDS > 256) begin : g_bad_depth
    $error("BUF_WORDS must lie in 2..256");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic              disk_hi;
    logic              selftest;
    logic              debug;
    logic [2:0]        req_sel;
    logic [7:0]        blen;
    logic [7:0]        brk;
    logic [4:0]        istat;
    logic [4:0]        imask;
    logic [3:0]        busy;
    logic [3:0]        done;
    logic [5:0][15:0]  pio;
    logic [15:0]       pio_rdata;
    logic              fill_sel;
    logic [1:0]        full;
    logic [PW-1:0]     fill_ptr;
    logic [1:0][PW-1:0] count;
    logic [PW-1:0]     drain_ptr;
    ch_state_t         ch;
    logic [8:0]        burst_cnt;
    logic [8:0]        break_cnt;
    logic              chan_valid;
  } state_t;

  state_t r, nxt;
  logic [15:0] mem [2][BUF_WORDS];
  logic [15:0] chan_data_r;
  logic        mem_we;
  logic        mem_rd;
  logic        req;
  logic        wr;
  logic        rd;
  logic [3:0]  masked;
  logic [3:0]  pending;
  logic [1:0]  int_port;
  logic        empty_sel;

  // map register index to owning port: 0,1 -> 0; 2,3 -> 1; 4 -> 2; 5 -> 3
  function automatic logic [1:0] owner(input logic [2:0] idx);
    logic [1:0] p;
    case (idx)
      3'd0, 3'd1: p = 2'd0;
      3'd2, 3'd3: p = 2'd1;
      3'd4:       p = 2'd2;
      default:    p = 2'd3;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // host interrupt priority
  // ----------------------------------------------------------------
  always_comb begin
    // disk/tape mapping follows the configured priority [RL5] [RL7]
    masked = 4'h0;
    masked[0] = r.disk_hi ? host_mask_i[`HOST_MASK_DISK]
                          : host_mask_i[`HOST_MASK_TAPE];
    masked[1] = r.disk_hi ? host_mask_i[`HOST_MASK_TAPE]
                          : host_mask_i[`HOST_MASK_DISK];
    pending = r.done & ~masked;
    // lowest index wins; maintenance port is last [RL3] [RL4] [RL6]
    int_port = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (pending[i]) begin
        int_port = 2'(i);
      end
    end
  end

  assign wr        = cyc_i && stb_i && we_i && !r.ack && sel_i == 4'hF;
  assign rd        = cyc_i && stb_i && !we_i && !r.ack;
  assign empty_sel = ~r.fill_sel;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]  ev;
    logic        xfer_end;
    logic        last;
    logic [2:0]  idx;
    ev       = 5'h00;
    xfer_end = 1'b0;
    last     = 1'b0;
    idx      = 3'd0;
    nxt      = r;
    mem_we   = 1'b0;
    mem_rd   = 1'b0;
    req      = 1'b0;
    nxt.ack        = cyc_i && stb_i && !r.ack;
    nxt.chan_valid = 1'b0;

    // host side command and status access [RL1] [RL2]
    if (pio_we_i && pio_reg_i < 3'd6) begin
      nxt.pio[pio_reg_i] = pio_wdata_i;
    end
    nxt.pio_rdata = (pio_reg_i < 3'd6) ? r.pio[pio_reg_i] : 16'h0000;
    // busy means a command is running, nothing about control blocks [RL9]
    if (pio_start_i && pio_reg_i < 3'd6) begin
      nxt.busy[owner(pio_reg_i)] = 1'b1; // [RL8]
      ev[owner(pio_reg_i)] = 1'b1;
    end
    if (host_int_ack_i && pending != 4'h0) begin
      nxt.done[int_port] = 1'b0;
    end

    // software writes
    if (wr) begin
      case (adr_i)
        `ADDR_CTRL: begin
          nxt.disk_hi  = dat_i[`CTRL_DISK_HI];
          nxt.selftest = dat_i[`CTRL_SELFTEST];
          nxt.debug    = dat_i[`CTRL_DEBUG];
          nxt.req_sel  = dat_i[`CTRL_REQ_LSB +: 3]; // [RL15]
          xfer_end     = dat_i[`CTRL_XFER_END];
        end
        `ADDR_BURST: begin
          nxt.blen = dat_i[7:0]; // [RL13]
          nxt.brk  = dat_i[`BURST_BRK_LSB +: 8]; // [RL14]
        end
        `ADDR_IRQ_MASK: nxt.imask = dat_i[4:0];
        `ADDR_DONE: begin
          // completion frees the port and posts its interrupt [RL8]
          // a command started in this same cycle on an idle port keeps its busy flag
          nxt.busy = (r.busy & ~dat_i[3:0]) | (nxt.busy & ~r.busy);
          nxt.done = nxt.done | dat_i[3:0];
        end
        `ADDR_BUFDATA: begin
          if (!r.full[r.fill_sel]) begin
            mem_we       = 1'b1;
            nxt.fill_ptr = r.fill_ptr + PW'(1);
            if (r.fill_ptr == PW'(BUF_WORDS - 1)) begin
              nxt.full[r.fill_sel]  = 1'b1; // [RL11]
              nxt.count[r.fill_sel] = PW'(BUF_WORDS);
            end
          end
        end
        default: begin
          idx = 3'(adr_i[4:2]);
          if (adr_i >= `ADDR_PIO_BASE && adr_i <= `ADDR_PIO_LAST) begin
            nxt.pio[idx] = dat_i[15:0];
          end
        end
      endcase
    end
    // a partly filled buffer is closed by the end-of-transfer bit
    if (xfer_end && !r.full[r.fill_sel] && r.fill_ptr != '0) begin
      nxt.full[r.fill_sel]  = 1'b1;
      nxt.count[r.fill_sel] = r.fill_ptr;
    end

    // software reads
    nxt.rdata = 32'h0000_0000;
    if (rd) begin
      case (adr_i)
        `ADDR_CTRL: begin
          nxt.rdata[`CTRL_DISK_HI]     = r.disk_hi;
          nxt.rdata[`CTRL_SELFTEST]    = r.selftest;
          nxt.rdata[`CTRL_DEBUG]       = r.debug;
          nxt.rdata[`CTRL_REQ_LSB +: 3] = r.req_sel;
        end
        `ADDR_BURST: begin
          nxt.rdata[7:0] = r.blen;
          nxt.rdata[`BURST_BRK_LSB +: 8] = r.brk;
        end
        `ADDR_IRQ_STAT: nxt.rdata[4:0] = r.istat;
        `ADDR_IRQ_MASK: nxt.rdata[4:0] = r.imask;
        `ADDR_DONE: begin
          nxt.rdata[3:0] = r.busy;
          nxt.rdata[`DONE_FLAG_LSB +: 4] = r.done;
        end
        `ADDR_BUFDATA: begin
          nxt.rdata[0]   = r.fill_sel;
          nxt.rdata[2:1] = r.full;
          nxt.rdata[3]   = (r.ch == CH_XFER);
        end
        default: begin
          idx = 3'(adr_i[4:2]);
          if (adr_i >= `ADDR_PIO_BASE && adr_i <= `ADDR_PIO_LAST) begin
            nxt.rdata[15:0] = r.pio[idx];
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // burst channel sequencer
    // ----------------------------------------------------------------
    case (r.ch)
      CH_IDLE: begin
        if (r.full[empty_sel]) begin
          nxt.ch = CH_REQ;
        end
      end
      CH_REQ: begin
        req = 1'b1;
        if (chan_grant_i) begin
          nxt.ch        = CH_XFER;
          nxt.burst_cnt = 9'd0;
        end
      end
      CH_XFER: begin
        mem_rd         = 1'b1;
        nxt.chan_valid = 1'b1;
        nxt.drain_ptr  = r.drain_ptr + PW'(1);
        nxt.burst_cnt  = r.burst_cnt + 9'd1;
        last = (r.drain_ptr + PW'(1) == r.count[empty_sel]);
        if (last) begin
          // buffer empties to host alongside filling [RL12]
          nxt.full[empty_sel] = 1'b0;
          nxt.drain_ptr       = '0;
          ev[`IRQ_DRAINED]    = 1'b1;
        end
        if (last || r.burst_cnt == {1'b0, r.blen}) begin // [RL13]
          nxt.ch        = CH_BREAK;
          nxt.break_cnt = 9'd0;
        end
      end
      CH_BREAK: begin
        // gap counts sync periods, blen/brk hold count minus one [RL14]
        if (chan_sync_i) begin
          nxt.break_cnt = r.break_cnt + 9'd1;
          if (r.break_cnt == {1'b0, r.brk}) begin
            nxt.ch = CH_IDLE;
          end
        end
      end
      default: nxt.ch = CH_IDLE;
    endcase

    // swap once filling side is closed and draining side is empty [RL19]
    if (nxt.full[r.fill_sel] && !nxt.full[empty_sel] && r.ch != CH_XFER)
    begin
      nxt.fill_sel = empty_sel; // [RL11]
      nxt.fill_ptr = '0;
    end

    // sticky events; a read clears, a same-cycle event survives
    if (rd && adr_i == `ADDR_IRQ_STAT) begin
      nxt.istat = ev;
    end else begin
      nxt.istat = r.istat | ev;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r           <= '0;
      r.blen      <= `RST_BURST_LEN;
      r.brk       <= `RST_BREAK_CNT;
      r.ch        <= CH_IDLE;
    end else begin
      r <= nxt;
    end
  end

  // buffer memory kept outside the state word to stay a plain RAM
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[r.fill_sel][r.fill_ptr[AW-1:0]] <= dat_i[15:0];
    end
    if (mem_rd) begin
      chan_data_r <= mem[empty_sel][r.drain_ptr[AW-1:0]];
    end
    if (rst_i) begin
      chan_data_r <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < `REQ_LINES; g++) begin : g_req
      assign chan_req_o[g] = req && (r.req_sel == 3'(g)); // [RL15]
    end
  endgenerate

  assign dat_o             = r.rdata;
  assign ack_o             = r.ack;
  assign irq_o             = |(r.istat & r.imask);
  assign pio_rdata_o       = r.pio_rdata;
  assign pio_busy_o        = r.busy;
  assign pio_done_o        = r.done;
  assign host_int_o        = |pending; // [RL4]
  assign host_int_port_o   = int_port;
  assign chan_data_o       = chan_data_r;
  assign chan_valid_o      = r.chan_valid;
  assign dch_req_o         = 1'b0; // [RL16]
  assign led_busy_o        = r.busy; // [RL10]
  assign led_chan_active_o = (r.ch == CH_XFER) || r.chan_valid; // [RL17]
  assign led_selftest_o    = r.selftest || r.debug; // [RL18]

endmodule

// ===== hw/host_port_consts.svh
// Purpose: offsets, field positions, reset values and counts of the
//          host programmed-I/O ports and burst channel buffer block
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes:   included by the package and the block
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_CTRL     8'h00
`define ADDR_BURST    8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_MASK 8'h0C
`define ADDR_DONE     8'h10
`define ADDR_BUFDATA  8'h14
`define ADDR_PIO_BASE 8'h20
`define ADDR_PIO_LAST 8'h34

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_DISK_HI   0
`define CTRL_SELFTEST  1
`define CTRL_DEBUG     2
`define CTRL_REQ_LSB   3
`define CTRL_XFER_END  6
`define BURST_BRK_LSB  8
`define IRQ_DRAINED    4
`define DONE_FLAG_LSB  4
`define HOST_MASK_TAPE 10
`define HOST_MASK_DISK 7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RST_BURST_LEN  8'hFF
`define RST_BREAK_CNT  8'h00
`define PORT_COUNT     4
`define PIO_REG_COUNT  6
`define REQ_LINES      8

`endif

// ===== hw/host_port_pkg.sv
// Purpose: shared types of the host port block
// Assumes: constants come from host_port_consts.svh
// Notes:   channel sequencer states only
`include "host_port_consts.svh"
package host_port_pkg;
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_REQ,
    CH_XFER,
    CH_BREAK
  } ch_state_t;
endpackage

// ===== bench/chan_partner.sv
// Purpose: far side of the burst channel, grant and sync clock
// Assumes: request and grant sampled on clk_i
// Notes:   grant delay comes from the bench to model slow arbitration
`timescale 1ns/1ns
module chan_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] req_i,
  input  wire logic [2:0] line_i,
  input  wire logic [3:0] wait_i,
  output logic            grant_o,
  output logic            sync_o
);
  logic [3:0] w_r;
  logic [1:0] s_r;
  // sync clock runs free, one pulse every four cycles
  assign sync_o  = (s_r == 2'h3);
  // only the configured request line is ever answered
  assign grant_o = req_i[line_i] && (w_r == wait_i);
  always_ff @(posedge clk_i) begin
    s_r <= rst_i ? 2'h0 : s_r + 2'h1;
    if (rst_i || !req_i[line_i]) begin
      w_r <= 4'h0;
    end else if (w_r != wait_i) begin
      w_r <= w_r + 4'h1;
    end
  end
endmodule

// ===== bench/host_port_monitor.sv
// Purpose: concurrent checks on the host port block
// Assumes: one clock, rst_i synchronous active high
// Notes:   bound into every instance of the block
`timescale 1ns/1ns
module host_port_monitor (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       pio_start_i,
  input wire logic [2:0] pio_reg_i,
  input wire logic [3:0] pio_busy_o,
  input wire logic [3:0] pio_done_o,
  input wire logic       host_int_o,
  input wire logic [1:0] host_int_port_o,
  input wire logic [7:0] chan_req_o,
  input wire logic       chan_grant_i,
  input wire logic       chan_valid_o,
  input wire logic       dch_req_o,
  input wire logic [3:0] led_busy_o,
  input wire logic       led_chan_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [8:0] run_r;
  // saturating count of back-to-back words bounds one burst
  always_ff @(posedge clk_i) begin
    if (rst_i || !chan_valid_o) begin
      run_r <= 9'h000;
    end else if (run_r != 9'h1FF) begin
      run_r <= run_r + 9'h001;
    end
  end
  property p_led_busy;
    led_busy_o == pio_busy_o;
  endproperty
  a_led_busy: assert property (p_led_busy)
    else $error("busy indicator differs from flag");
  property p_no_dch;
    dch_req_o == 1'b0;
  endproperty
  a_no_dch: assert property (p_no_dch)
    else $error("data channel request raised");
  property p_one_line;
    $onehot0(chan_req_o);
  endproperty
  a_one_line: assert property (p_one_line)
    else $error("more than one request line");
  property p_active;
    chan_valid_o |-> led_chan_active_o;
  endproperty
  a_active: assert property (p_active)
    else $error("activity indicator dark during word");
  property p_start_busy;
    pio_start_i && pio_reg_i == 3'h4 |=> pio_busy_o[2];
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("port 2 busy not set by command");
  property p_prio;
    pio_done_o[2] |-> host_int_o && host_int_port_o <= 2'h2;
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower port presented over port 2");
  property p_run;
    run_r <= 9'h100;
  endproperty
  a_run: assert property (p_run)
    else $error("burst longer than 256 words");
  property p_grant;
    (|chan_req_o) && chan_grant_i |=> chan_req_o == 8'h00 ##1 chan_valid_o;
  endproperty
  a_grant: assert property (p_grant)
    else $error("no word two cycles after grant");
endmodule
bind host_pio_ports_burst_buffer host_port_monitor u_mon (
  .clk_i, .rst_i, .pio_start_i, .pio_reg_i, .pio_busy_o, .pio_done_o,
  .host_int_o, .host_int_port_o, .chan_req_o, .chan_grant_i,
  .chan_valid_o, .dch_req_o, .led_busy_o, .led_chan_active_o
);

// ===== bench/host_pio_ports_burst_buffer_test.sv
// Purpose: self-checking bench for the host port and burst buffer block
// Assumes: far side is chan_partner; buffers shrunk to 8 words
// Notes:   one task per scenario, bus cycles through wb
`timescale 1ns/1ns
module host_pio_ports_burst_buffer_test;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
  logic        pio_we_i, pio_start_i, host_int_ack_i, host_int_o;
  logic        chan_grant_i, chan_sync_i, chan_valid_o, dch_req_o;
  logic        led_chan_active_o, led_selftest_o;
  logic [7:0]  adr_i, chan_req_o;
  logic [3:0]  sel_i, pio_busy_o, pio_done_o, led_busy_o;
  logic [2:0]  pio_reg_i;
  logic [1:0]  host_int_port_o;
  logic [15:0] pio_wdata_i, pio_rdata_o, host_mask_i, chan_data_o;
  logic [31:0] dat_i, dat_o;
  logic [15:0] words[$];
  int          bad_count, n_compared, run, max_run, syncs, min_gap, bad_req;

  host_pio_ports_burst_buffer #(.BUF_WORDS(8)) u_dut (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .irq_o, .pio_we_i, .pio_reg_i, .pio_wdata_i, .pio_start_i,
    .pio_rdata_o, .pio_busy_o, .pio_done_o, .host_mask_i, .host_int_o,
    .host_int_port_o, .host_int_ack_i, .chan_req_o, .chan_grant_i,
    .chan_sync_i, .chan_data_o, .chan_valid_o, .dch_req_o, .led_busy_o,
    .led_chan_active_o, .led_selftest_o
  );
  chan_partner u_far (
    .clk_i, .rst_i, .req_i(chan_req_o), .line_i(3'h5), .wait_i(4'h6),
    .grant_o(chan_grant_i), .sync_o(chan_sync_i)
  );

  // word collector: burst lengths and sync periods between bursts
  always @(posedge clk_i) begin
    if (chan_sync_i) syncs++;
    if (chan_req_o != 8'h00 && chan_req_o !== 8'h20) bad_req++;
    if (chan_valid_o) begin
      if (run == 0 && words.size() > 0 && syncs < min_gap) min_gap = syncs;
      words.push_back(chan_data_o);
      run++;
      syncs = 0;
      if (run > max_run) max_run = run;
    end else begin
      run = 0;
    end
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 50);
    q = dat_o;
    if (ack_o !== 1'h1) begin
      bad_count++;
      end_sim;
    end
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask

  task automatic pio(input logic st, input logic [2:0] r,
                     input logic [15:0] d);
    @(posedge clk_i);
    pio_reg_i   <= r;
    pio_wdata_i <= d;
    pio_we_i    <= !st;
    pio_start_i <= st;
    @(posedge clk_i);
    pio_we_i    <= 1'h0;
    pio_start_i <= 1'h0;
    // let the flags launched at the sampling edge settle before checks
    @(posedge clk_i);
  endtask

  task automatic ackp;
    @(posedge clk_i);
    host_int_ack_i <= 1'h1;
    @(posedge clk_i);
    host_int_ack_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic s_pio;
    logic [31:0] q;
    wb(1, 8'h0C, 32'h0000_001F, q);
    pio(0, 3'h3, 16'hA5C3);
    wb(0, 8'h2C, '0, q);
    chk("pio_reg3", q, 32'h0000_A5C3);
    chk("pio_rdata", pio_rdata_o, 32'h0000_A5C3);
    pio(1, 3'h4, '0);
    chk("busy_p2", {irq_o, pio_busy_o}, 5'h14);
    pio(1, 3'h5, '0);
    chk("led_busy", led_busy_o, 4'hC);
    wb(0, 8'h08, '0, q);
    chk("irq_stat", q, 32'h0000_000C);
    wb(0, 8'h08, '0, q);
    chk("irq_clr", {q[4:0], irq_o}, 6'h00);
    wb(1, 8'h10, 32'h0000_0008, q);
    chk("done3", {pio_busy_o, pio_done_o}, 8'h48);
    chk("int_p3", {host_int_o, host_int_port_o}, 3'h7);
    wb(1, 8'h10, 32'h0000_0004, q);
    chk("int_p2", {host_int_o, host_int_port_o}, 3'h6);
    ackp;
    chk("int_p3b", {host_int_o, host_int_port_o}, 3'h7);
    ackp;
    chk("int_off", {host_int_o, pio_done_o}, 5'h00);
  endtask

  task automatic s_mask;
    logic [31:0] q;
    host_mask_i <= 16'h0400;
    wb(1, 8'h00, '0, q);
    pio(1, 3'h0, '0);
    wb(1, 8'h10, 32'h0000_0001, q);
    chk("tape_masked", {host_int_o, pio_done_o}, 5'h01);
    wb(1, 8'h00, 32'h0000_0001, q);
    chk("disk_p0", {host_int_o, host_int_port_o}, 3'h4);
    host_mask_i <= 16'h0080;
    @(posedge clk_i);
    chk("disk_masked", host_int_o, 1'h0);
    host_mask_i <= '0;
    ackp;
    chk("p0_clr", pio_done_o, 4'h0);
  endtask

  task automatic s_misc;
    logic [31:0] q;
    logic [31:0] v[3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0000};
    foreach (v[i]) begin
      wb(1, 8'h00, v[i], q);
      chk("selftest", led_selftest_o, v[i] != 0);
    end
    wb(0, 8'hFC, '0, q);
    chk("unmapped", q, '0);
    chk("dch_idle", dch_req_o, 1'h0);
  endtask

  task automatic s_burst;
    logic [31:0] q;
    wb(1, 8'h00, 32'h0000_0029, q);
    wb(1, 8'h04, 32'h0000_0103, q);
    // words past the eighth fill the second buffer while the first empties
    for (int i = 0; i < 11; i++) wb(1, 8'h14, 32'h1000 + i, q);
    wb(1, 8'h00, 32'h0000_0069, q);
    for (int n = 0; n < 3000 && words.size() < 11; n++) @(posedge clk_i);
    if (words.size() < 11) begin
      bad_count++;
      end_sim;
    end
    foreach (words[i]) chk("word", words[i], 16'h1000 + i);
    chk("max_run", 32'(max_run), 32'h0000_0004);
    chk("gap", min_gap >= 2, 1'h1);
    chk("req_line", 32'(bad_req), '0);
    // port 0 start left over from the mask scenario plus the drain event
    wb(0, 8'h08, '0, q);
    chk("drained", q, 32'h0000_0011);
  endtask

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'h1;
    {cyc_i, stb_i, we_i, pio_we_i, pio_start_i, host_int_ack_i} = '0;
    {adr_i, dat_i, pio_reg_i, pio_wdata_i, host_mask_i} = '0;
    sel_i = 4'hF;
    min_gap = 99;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    s_pio;
    s_mask;
    s_misc;
    s_burst;
    end_sim;
  end
endmodule
